// ---- mft_ctl.sv ----
// mode and interrupt control of the dual multi-function timer
// Summary of operation
// - two-bit mode field picks one of four modes
// - pin A edge bit: 0 falling, 1 rising
// - pin B edge bit: 0 falling, 1 rising
// - pulse accumulate gated by pin B level
// - mode 1 pin A edge presets counter one
// - other modes: enabled pin A is PWM output
// - pin B edge presets counter one or two
// - output state bit drives pin, software writable
// - software write beats hardware toggle
// - output state bit ignored while pin A input
// - disabled module stops clocks, blocks pending sets
// - disabled: prescaler, pendings cleared, pin A input
// - mode and interrupt registers reset to zero
// - pending set by hardware or software one
// - enable bits gate each interrupt source
// - writing one to clear bit clears pending
// - clear register reads as all ones
// - PWM pin toggles on counter one underflow
// - source A: reload A or pin A capture
// - source D: reload B mode 2, else underflow
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "mft_ctl_defines.svh"
module mft_ctl (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire mft_ctl_pkg::mft_bus_req_type bus_req,
   output logic [7:0] bus_rdata,
   // datapath strobes in and control out
   input wire mft_ctl_pkg::mft_events_type events,
   output mft_ctl_pkg::mft_ctl_out_type ctl_out,
   output logic [4:0] prescaler,
   // timer pins
   input wire logic timer_pin_a_i,
   output logic timer_pin_a_o,
   output logic timer_pin_a_oe,
   input wire logic timer_pin_b_i,
   // system interrupt requests
   output logic irq_one,
   output logic irq_two
);
   import mft_ctl_pkg::*;

   mft_state_type state_q;
   mft_state_type state_d;

   // decode of the two-bit mode field into one-hot form
   function automatic mft_mode_type decode_mode(input logic [1:0] f);
      case (f)
         2'h0: decode_mode = MFT_MODE_PWM;
         2'h1: decode_mode = MFT_MODE_DUAL_CAP;
         2'h2: decode_mode = MFT_MODE_DUAL_CNT;
         default: decode_mode = MFT_MODE_SINGLE_CAP;
      endcase
   endfunction

   // selected edge: rising when sel is 1, falling when 0
   function automatic logic edge_hit(input logic prev, input logic now, input logic sel);
      edge_hit = sel ? (!prev && now) : (prev && !now);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   mft_mode_type mode;
   logic enabled;
   logic edge_a;
   logic edge_b;
   logic wr_mode;
   logic wr_intc;
   logic wr_clr;
   logic [3:0] hw_set;
   logic [3:0] pend;

   always_comb begin
      mode = decode_mode(state_q.mode_reg[1:0]);
      enabled = state_q.mode_reg[`MFT_BIT_ENABLE];
      edge_a = edge_hit(state_q.prev_a, state_q.sync_a[1], state_q.mode_reg[`MFT_BIT_EDGE_A]);
      edge_b = edge_hit(state_q.prev_b, state_q.sync_b[1], state_q.mode_reg[`MFT_BIT_EDGE_B]);
      wr_mode = bus_req.wr && (bus_req.addr == `MFT_ADDR_MODE);
      wr_intc = bus_req.wr && (bus_req.addr == `MFT_ADDR_INTC);
      wr_clr = bus_req.wr && (bus_req.addr == `MFT_ADDR_ICLR);
      hw_set = 4'h0;
      case (mode)
         MFT_MODE_PWM: begin
            hw_set[0] = events.reload_a;
            hw_set[1] = events.reload_b_one;
            hw_set[3] = events.underflow_two;
         end
         MFT_MODE_DUAL_CAP: begin
            hw_set[0] = state_q.mode_reg[`MFT_BIT_EN_A] ? edge_a : 1'b0;
            hw_set[1] = edge_b;
            hw_set[2] = events.underflow_one;
            hw_set[3] = events.underflow_two;
         end
         MFT_MODE_DUAL_CNT: begin
            hw_set[0] = events.reload_a;
            hw_set[3] = events.reload_b_two;
         end
         MFT_MODE_SINGLE_CAP: begin
            hw_set[0] = events.reload_a;
            hw_set[1] = edge_b;
            hw_set[3] = events.underflow_two;
         end
         default: hw_set = 4'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      state_d.sync_a = {state_q.sync_a[0], timer_pin_a_i};
      state_d.sync_b = {state_q.sync_b[0], timer_pin_b_i};
      state_d.prev_a = state_q.sync_a[1];
      state_d.prev_b = state_q.sync_b[1];
      // register file
      if (wr_mode) begin
         state_d.mode_reg = bus_req.wdata;
      end else if (enabled && (mode != MFT_MODE_DUAL_CAP) && state_q.mode_reg[`MFT_BIT_EN_A]
                   && events.underflow_one) begin
         state_d.mode_reg[`MFT_BIT_OUT_A] = !state_q.mode_reg[`MFT_BIT_OUT_A];
      end
      pend = state_q.intc_reg[3:0];
      if (wr_intc) begin
         state_d.intc_reg[7:4] = bus_req.wdata[7:4];
         if (enabled) begin
            pend = pend | bus_req.wdata[3:0];
         end
      end
      if (wr_clr) begin
         pend = pend & ~bus_req.wdata[3:0];
      end
      pend = pend | hw_set;
      state_d.intc_reg[3:0] = enabled ? pend : 4'h0;
      if (!enabled) begin
         state_d.prescaler = `MFT_PSC_RESET;
      end else begin
         state_d.prescaler = state_q.prescaler + 5'h01;
      end
      // read data one cycle after the strobe
      state_d.rdata = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            `MFT_ADDR_MODE: state_d.rdata = state_q.mode_reg;
            `MFT_ADDR_INTC: state_d.rdata = state_q.intc_reg;
            `MFT_ADDR_ICLR: state_d.rdata = `MFT_ICLR_READ;
            default: state_d.rdata = 8'h00;
         endcase
      end
      // pin A: output only when enabled, pin A enabled and outside dual capture mode
      state_d.pin_a_oe = enabled && state_q.mode_reg[`MFT_BIT_EN_A] && (mode != MFT_MODE_DUAL_CAP);
      // the state bit reaches the pin only while it drives
      state_d.pin_a_o = state_d.pin_a_oe ? state_d.mode_reg[`MFT_BIT_OUT_A] : 1'b0;
      // datapath control
      state_d.ctl.clk_run = enabled;
      state_d.ctl.preset_one = enabled && (((mode == MFT_MODE_DUAL_CAP) && state_q.mode_reg[`MFT_BIT_EN_A] && edge_a)
                               || ((mode == MFT_MODE_DUAL_CAP) && state_q.mode_reg[`MFT_BIT_EN_B] && edge_b));
      state_d.ctl.preset_two = enabled && (mode == MFT_MODE_SINGLE_CAP) && state_q.mode_reg[`MFT_BIT_EN_B]
                               && edge_b;
      state_d.ctl.capture_a = enabled && (mode == MFT_MODE_DUAL_CAP) && edge_a;
      state_d.ctl.capture_b = enabled && ((mode == MFT_MODE_DUAL_CAP) || (mode == MFT_MODE_SINGLE_CAP)) && edge_b;
      // pulse accumulate: count while pin B sits at the chosen level
      state_d.ctl.count_enable = (state_q.sync_b[1] == state_q.mode_reg[`MFT_BIT_EDGE_B]);
      state_d.irq_one = |(state_d.intc_reg[2:0] & state_d.intc_reg[6:4]);
      state_d.irq_two = state_d.intc_reg[3] & state_d.intc_reg[7];
      if (rst) begin
         state_d = '0;
         state_d.mode_reg = `MFT_MODE_RESET;
         state_d.intc_reg = `MFT_INTC_RESET;
      end
   end

   always_ff @(posedge clk) begin
      state_q <= state_d;
   end

   assign bus_rdata = state_q.rdata;
   assign ctl_out = state_q.ctl;
   assign prescaler = state_q.prescaler;
   assign timer_pin_a_o = state_q.pin_a_o;
   assign timer_pin_a_oe = state_q.pin_a_oe;
   assign irq_one = state_q.irq_one;
   assign irq_two = state_q.irq_two;

   ////////////////////////////////////////////////////////////////////////
   sequence s_clr_write;
      bus_req.wr && bus_req.addr == `MFT_ADDR_ICLR && !wr_intc;
   endsequence

   a_clear_reads_ones: assert property (@(posedge clk) disable iff (rst)
      bus_req.rd && bus_req.addr == `MFT_ADDR_ICLR |=> bus_rdata == `MFT_ICLR_READ) else $error("clear reg not FF");
   a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
      enabled && hw_set[0] |=> state_q.intc_reg[0]) else $error("hardware set lost");
   a_clear_pending: assert property (@(posedge clk) disable iff (rst)
      s_clr_write ##0 (bus_req.wdata[1] && !hw_set[1] && !wr_mode) |=> !state_q.intc_reg[1]) else $error("clear failed");
   a_zero_write_ign: assert property (@(posedge clk) disable iff (rst)
      wr_intc && state_q.intc_reg[2] && !wr_clr |=> state_q.intc_reg[2] || !$past(enabled)) else $error("zero cleared");
   a_disabled_clear: assert property (@(posedge clk) disable iff (rst)
      !enabled && !wr_mode |=> state_q.intc_reg[3:0] == 4'h0 && prescaler == 5'h00) else $error("not cleared");
   a_disabled_input: assert property (@(posedge clk) disable iff (rst)
      !enabled && !wr_mode |=> !timer_pin_a_oe) else $error("pin A driven while off");
   a_sw_wins_toggle: assert property (@(posedge clk) disable iff (rst)
      wr_mode |=> state_q.mode_reg == $past(bus_req.wdata)) else $error("software write lost");
   a_irq_two_follows: assert property (@(posedge clk) disable iff (rst)
      ##1 irq_two == (state_q.intc_reg[3] & state_q.intc_reg[7])) else $error("irq two wrong");
   // compare with the state bit, not the pin: a write just before the underflow moves the bit first
   a_pwm_toggle: assert property (@(posedge clk) disable iff (rst)
      enabled && mode == MFT_MODE_PWM && state_q.mode_reg[`MFT_BIT_EN_A] && events.underflow_one && !wr_mode
      |=> timer_pin_a_o != $past(state_q.mode_reg[`MFT_BIT_OUT_A])) else $error("pwm no toggle");
   a_pin_a_preset: assert property (@(posedge clk) disable iff (rst)
      enabled && mode == MFT_MODE_DUAL_CAP && state_q.mode_reg[`MFT_BIT_EN_A] && edge_a
      |=> ctl_out.preset_one) else $error("pin A preset missing");
   a_pin_b_preset: assert property (@(posedge clk) disable iff (rst)
      enabled && mode == MFT_MODE_SINGLE_CAP && state_q.mode_reg[`MFT_BIT_EN_B] && edge_b
      |=> ctl_out.preset_two) else $error("pin B preset missing");
   a_no_preset_off: assert property (@(posedge clk) disable iff (rst)
      !enabled |=> !ctl_out.preset_one && !ctl_out.preset_two && !ctl_out.clk_run) else $error("preset while off");
   a_dual_cnt_quiet: assert property (@(posedge clk) disable iff (rst)
      mode == MFT_MODE_DUAL_CNT |=> !ctl_out.capture_b && !ctl_out.preset_two && !ctl_out.preset_one)
      else $error("pin B acted in dual counter mode");
   a_sw_pend_set: assert property (@(posedge clk) disable iff (rst)
      wr_intc && enabled
      |=> (state_q.intc_reg[3:0] & $past(bus_req.wdata[3:0])) == $past(bus_req.wdata[3:0]))
      else $error("software set lost");
endmodule

// ---- mft_ctl_bench.sv ----
// self-checking bench of the timer control block
`timescale 1ns/100ps
`include "mft_ctl_defines.svh"
module mft_ctl_bench;
   import mft_ctl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   mft_bus_req_type bus_req = '0;
   mft_events_type events = '0;
   mft_ctl_out_type ctl_out;
   logic [7:0] bus_rdata;
   logic [4:0] prescaler;
   logic pin_a_o, pin_a_oe, pin_a, pin_b, irq_one, irq_two;
   logic drv_a = 1'b1;
   logic drv_b = 1'b1;
   logic [7:0] r, c;
   int fails = 0;
   int samples_checked = 0;
   int presets = 0;
   int captures = 0;
   int seed = 32'h1baa3ae6;
   initial begin
      forever #25 clk = ~clk;
   end
   mft_ctl u_mft_ctl (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .events(events),
      .ctl_out(ctl_out), .prescaler(prescaler), .timer_pin_a_i(pin_a), .timer_pin_a_o(pin_a_o),
      .timer_pin_a_oe(pin_a_oe), .timer_pin_b_i(pin_b), .irq_one(irq_one), .irq_two(irq_two));
   mft_pin_model u_mft_pin_model (.clk(clk), .drv_a(drv_a), .drv_b(drv_b), .a_o(pin_a_o), .a_oe(pin_a_oe),
      .pin_a(pin_a), .pin_b(pin_b));
   always @(posedge clk) presets <= presets + (ctl_out.preset_one | ctl_out.preset_two);
   always @(posedge clk) captures <= captures + (ctl_out.capture_a | ctl_out.capture_b);
   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic both(input logic [2:0] a, input logic [7:0] d, input mft_events_type e);
      @(posedge clk) begin
         bus_req <= '{a, d, 1'b1, 1'b0};
         events <= e;
      end
      @(posedge clk) begin
         bus_req <= '0;
         events <= '0;
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      both(a, d, '0);
   endtask
   task automatic pulse(input mft_events_type e);
      @(posedge clk) events <= e;
      @(posedge clk) events <= '0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus_req <= '0;
      #1 check(bus_rdata, exp);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(`MFT_ADDR_MODE, `MFT_MODE_RESET);
      rd(`MFT_ADDR_INTC, `MFT_INTC_RESET);
      rd(`MFT_ADDR_ICLR, `MFT_ICLR_READ);
      rd(3'h3, 8'h00);
      wr(`MFT_ADDR_INTC, 8'hFF);
      pulse(5'h1F);
      rd(`MFT_ADDR_INTC, 8'hF0);
      check({2'h0, ctl_out.clk_run, prescaler}, 8'h00);
      wr(`MFT_ADDR_MODE, 8'h80);
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         c = $random(seed);
         wr(`MFT_ADDR_INTC, r);
         rd(`MFT_ADDR_INTC, r);
         check({6'h00, irq_one, irq_two}, {6'h00, |(r[2:0] & r[6:4]), r[3] & r[7]});
         wr(`MFT_ADDR_ICLR, c);
         rd(`MFT_ADDR_INTC, {r[7:4], r[3:0] & ~c[3:0]});
         wr(`MFT_ADDR_ICLR, 8'h0F);
      end
      wr(`MFT_ADDR_INTC, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(`MFT_ADDR_MODE, 8'h80 | 8'(m));
         wr(`MFT_ADDR_ICLR, 8'h0F);
         pulse(5'h0C);
         rd(`MFT_ADDR_INTC, {4'h0, m != 2, 2'b00, m != 1});
         wr(`MFT_ADDR_ICLR, 8'h0F);
         pulse(5'h13);
         rd(`MFT_ADDR_INTC, {4'h0, m == 2, m == 1, m == 0, 1'b0});
      end
      both(`MFT_ADDR_ICLR, 8'h0F, 5'h08);
      rd(`MFT_ADDR_INTC, 8'h08);
      wr(`MFT_ADDR_MODE, 8'h90);
      settle;
      check({6'h00, pin_a_oe, pin_a_o}, 8'h02);
      pulse(5'b10000);
      settle;
      check({6'h00, pin_a_oe, pin_a_o}, 8'h03);
      rd(`MFT_ADDR_MODE, 8'hD0);
      both(`MFT_ADDR_MODE, 8'hD0, 5'b10000);
      settle;
      check({6'h00, pin_a_oe, pin_a_o}, 8'h03);
      wr(`MFT_ADDR_MODE, 8'h90);
      settle;
      check({6'h00, pin_a_oe, pin_a_o}, 8'h02);
      wr(`MFT_ADDR_MODE, 8'h50);
      settle;
      check({6'h00, pin_a_oe, pin_a_o}, 8'h00);
      for (int e = 0; e < 2; e++) begin
         wr(`MFT_ADDR_MODE, 8'h91 | 8'(e << 2));
         wr(`MFT_ADDR_ICLR, 8'h0F);
         @(posedge clk) drv_a <= e[0];
         repeat (6) @(posedge clk);
         rd(`MFT_ADDR_INTC, 8'h01);
         wr(`MFT_ADDR_MODE, 8'hA3 | 8'(e << 3));
         wr(`MFT_ADDR_ICLR, 8'h0F);
         @(posedge clk) drv_b <= e[0];
         repeat (6) @(posedge clk);
         rd(`MFT_ADDR_INTC, 8'h02);
      end
      wr(`MFT_ADDR_MODE, 8'h95);
      wr(`MFT_ADDR_ICLR, 8'h0F);
      @(posedge clk) drv_a <= 1'b0;
      repeat (6) @(posedge clk);
      rd(`MFT_ADDR_INTC, 8'h00);
      check(8'(presets), 8'h04);
      check(8'(captures), 8'h04);
      wr(`MFT_ADDR_MODE, 8'h8A);
      settle;
      check({7'h00, ctl_out.count_enable}, 8'h01);
      wr(`MFT_ADDR_MODE, 8'h82);
      settle;
      check({7'h00, ctl_out.count_enable}, 8'h00);
      final_report;
   end
   initial begin
      #(50 * 20000);
      fails++;
      final_report;
   end
endmodule

// ---- mft_ctl_defines.svh ----
// offsets, field positions and reset values of the timer control block
`ifndef MFT_CTL_DEFINES_SVH
`define MFT_CTL_DEFINES_SVH
`define MFT_ADDR_MODE 3'h6
`define MFT_ADDR_INTC 3'h7
`define MFT_ADDR_ICLR 3'h0
`define MFT_MODE_RESET 8'h00
`define MFT_INTC_RESET 8'h00
`define MFT_ICLR_READ 8'hFF
`define MFT_BIT_EDGE_A 2
`define MFT_BIT_EDGE_B 3
`define MFT_BIT_EN_A 4
`define MFT_BIT_EN_B 5
`define MFT_BIT_OUT_A 6
`define MFT_BIT_ENABLE 7
`define MFT_PSC_RESET 5'h00
`endif

// ---- mft_ctl_pkg.sv ----
// types of the timer control block
package mft_ctl_pkg;
   typedef enum logic [3:0] {
      MFT_MODE_PWM = 4'h1,
      MFT_MODE_DUAL_CAP = 4'h2,
      MFT_MODE_DUAL_CNT = 4'h4,
      MFT_MODE_SINGLE_CAP = 4'h8
   } mft_mode_type;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mft_bus_req_type;
   typedef struct packed {
      logic underflow_one;
      logic underflow_two;
      logic reload_a;
      logic reload_b_one;
      logic reload_b_two;
   } mft_events_type;
   typedef struct packed {
      logic preset_one;
      logic preset_two;
      logic capture_a;
      logic capture_b;
      logic count_enable;
      logic clk_run;
   } mft_ctl_out_type;
   typedef struct packed {
      logic [7:0] mode_reg;
      logic [7:0] intc_reg;
      logic [4:0] prescaler;
      logic [7:0] rdata;
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic prev_a;
      logic prev_b;
      logic irq_one;
      logic irq_two;
      logic pin_a_o;
      logic pin_a_oe;
      mft_ctl_out_type ctl;
   } mft_state_type;
endpackage

// ---- mft_pin_model.sv ----
// far-side model of the two timer pins, resolving the shared pin A wire
`timescale 1ns/100ps
module mft_pin_model (
   // clock
   input wire logic clk,
   // levels asked for by the bench
   input wire logic drv_a,
   input wire logic drv_b,
   // pin A driver of the timer
   input wire logic a_o,
   input wire logic a_oe,
   // resolved pins
   output logic pin_a,
   output logic pin_b
);
   logic a_q = 1'b1;
   logic b_q = 1'b1;
   // lines move one cycle after the request, like a slow external source
   always_ff @(posedge clk) begin
      a_q <= drv_a;
      b_q <= drv_b;
   end
   // the timer wins while it drives, so the model never fights it
   assign pin_a = a_oe ? a_o : a_q;
   assign pin_b = b_q;
endmodule
